// >>> design/mrss_sequencer.sv
// Reset source collector and reset stretch sequencer
`timescale 1ns/10ps

// Notes on behaviour
// (R1) Reset I/O registers; fetch reset vector on release (internal reset clears only the watchdog enable)
// (R2) Port pins reset asynchronously, no clock needed (watchdog and test-port resets reach them on a clock edge)
// (R3) Stretch counter starts after all sources inactive
// (R4) Stretch length chosen by clock select fuses
// (R5) Five independent sources, any one resets
// (R6) Supply below power-on threshold holds reset
// (R7) Long enough low pin pulse resets
// (R8) Watchdog expiry resets only when enabled
// (R9) Brown-out resets only when detector enabled
// (R10) Test-port reset register one holds reset
// (R11) Watchdog gives one-cycle pulse, count after
// (R12) Supply drop reasserts reset with no delay
// (R13) Raw reset is OR; reassert restarts count
module mrss_sequencer
    import mrss_pkg::*;
#(
    parameter int STRETCH_BASE_CYC = 16,          // Cycles for fuse setting zero
    parameter int CNT_W            = 32           // Stretch counter width
) (
    input  wire logic              i_clk,
    input  wire logic              i_rst_b,
    input  wire logic              i_por_low,             // Supply below power_on_threshold
    input  wire logic              i_ext_rst_pin_b,       // External reset pin, low resets
    input  wire logic              i_wdt_expire,          // Watchdog period expired
    input  wire logic              i_bod_low,             // Supply below brownout_threshold
    input  wire logic              i_test_rst_reg,        // Test-port reset register bit
    input  wire logic [FUSE_W-1:0] i_clock_select_fuses,  // Fuse time-out selection
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    output logic                   o_core_rst,            // Internal reset, high active
    output logic                   o_io_rst,              // Port pin reset, high active
    output logic                   o_fetch_go,            // One cycle at reset release
    output logic      [PC_W-1:0]   o_fetch_addr           // Address of first fetch
);

    // Synchroniser stages
    logic [SYNC_W-1:0] sync1_r;                   // First stage, read by second only
    logic [SYNC_W-1:0] sync2_r;                   // Second stage, safe to use
    logic [SYNC_W-1:0] sync_in;                   // Gathered raw inputs

    // Register file
    logic [DATA_W-1:0] ctrl_r;                    // Enables
    logic [DATA_W-1:0] rdata_r;                   // Read answer
    logic [DATA_W-1:0] rdata_nxt;

    // Source conditioning
    logic              wdt_en;
    logic              bod_en;
    logic              por_s;
    logic              ext_low_s;
    logic              bod_s;
    logic              test_s;
    logic [FUSE_W-1:0] fuse_s;
    logic [2:0]        ext_cnt_r;                 // Pin low run length
    logic              ext_ok;                    // Pin low long enough
    logic              wdt_pulse_r;               // One-cycle watchdog reset
    logic              raw_rst;                   // OR of all five sources
    logic              async_src;                 // Pin-level sources, unclocked

    // Sequencer
    mrss_state_t       state_r;
    mrss_state_t       state_nxt;
    logic [CNT_W-1:0]  cnt_r;
    logic [CNT_W-1:0]  cnt_nxt;
    logic [FUSE_W-1:0] fuse_r;                    // Fuses frozen per stretch
    logic [CNT_W-1:0]  tout_cyc;                  // Selected stretch length
    logic              core_rst_r;
    logic              io_rst_r;
    logic              fetch_go_r;
    logic [PC_W-1:0]   fetch_addr_r;

    assign sync_in = {i_clock_select_fuses, i_test_rst_reg, i_bod_low,
                      ~i_ext_rst_pin_b, i_por_low};

    // Two flops per pin-side lane
    genvar g;
    generate
        for (g = 0; g < SYNC_W; g++) begin : g_sync
            // Free running, so levels and fuses are already valid when reset lifts
            always_ff @(posedge i_clk) begin
                sync1_r[g] <= sync_in[g];
                sync2_r[g] <= sync1_r[g];
            end
        end
    endgenerate

    assign por_s     = sync2_r[SY_POR];
    assign ext_low_s = sync2_r[SY_EXT];
    assign bod_s     = sync2_r[SY_BOD];
    assign test_s    = sync2_r[SY_TEST];
    assign fuse_s    = sync2_r[SY_FUSE +: FUSE_W];
    assign wdt_en    = ctrl_r[CTRL_WDT_EN_BIT];
    assign bod_en    = ctrl_r[CTRL_BOD_EN_BIT];

    // Register writes; only the enables are writable
    // (R1) internal reset clears the watchdog enable
    // Brown-out enable survives, so a brown-out keeps holding its own reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ctrl_r <= CTRL_RST;
        end else if (core_rst_r) begin
            ctrl_r[CTRL_WDT_EN_BIT] <= CTRL_RST[CTRL_WDT_EN_BIT];
        end else if (i_wr && i_addr == REG_CTRL) begin
            ctrl_r <= i_wdata & 8'h03;
        end
    end

    // Read decode; unmapped offsets read zero
    always_comb begin
        if (i_addr == REG_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (i_addr == REG_STATUS) begin
            rdata_nxt = {core_rst_r, state_r == MRSS_STRETCH, state_r == MRSS_HOLD,
                         test_s, bod_s & bod_en, wdt_pulse_r, ext_ok, por_s};
        end else if (i_addr == REG_COUNT) begin
            rdata_nxt = cnt_r[DATA_W-1:0];
        end else if (i_addr == REG_FUSE) begin
            rdata_nxt = {4'h0, fuse_r};
        end else begin
            rdata_nxt = 8'h00;
        end
    end

    // Read data stands one cycle after the strobe only
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            rdata_r <= 8'h00;
        end else if (i_rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= 8'h00;
        end
    end

    // (R7) pin low filter
    // Short glitches still hit the unclocked path; only the clocked path filters
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            ext_cnt_r <= 3'h0;
        end else if (!ext_low_s) begin
            ext_cnt_r <= 3'h0;
        end else if (ext_cnt_r != EXT_MIN_CNT) begin
            ext_cnt_r <= ext_cnt_r + 3'h1;
        end
    end
    assign ext_ok = ext_low_s && (ext_cnt_r == EXT_MIN_CNT);

    // (R8) (R11) gated one-cycle watchdog pulse
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wdt_pulse_r <= 1'b0;
        end else begin
            wdt_pulse_r <= i_wdt_expire & wdt_en & ~wdt_pulse_r;
        end
    end

    // (R5) (R13) raw reset is the OR of five sources
    // (R6) (R9) (R10) power-on, gated brown-out, test-port
    assign raw_rst = por_s | ext_ok | wdt_pulse_r | (bod_s & bod_en) | test_s;

    // (R2) (R12) unclocked sources; watchdog and test are clocked anyway
    assign async_src = i_por_low | ~i_ext_rst_pin_b | (i_bod_low & bod_en);

    // (R4) stretch length doubles per fuse step
    assign tout_cyc = CNT_W'(STRETCH_BASE_CYC) << fuse_r;

    // Next state of the stretch sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            MRSS_HOLD: begin
                cnt_nxt = '0;
                if (!raw_rst) begin
                    state_nxt = MRSS_STRETCH;
                end
            end
            MRSS_STRETCH: begin
                // (R13) reassertion restarts the count
                if (raw_rst) begin
                    state_nxt = MRSS_HOLD;
                    cnt_nxt   = '0;
                // (R3) release after the full time-out
                end else if (cnt_r == tout_cyc - CNT_W'(1)) begin
                    state_nxt = MRSS_RUN;
                end else begin
                    cnt_nxt = cnt_r + CNT_W'(1);
                end
            end
            MRSS_RUN: begin
                if (raw_rst) begin
                    state_nxt = MRSS_HOLD;
                end
            end
            default: begin
                state_nxt = MRSS_HOLD;
            end
        endcase
    end

    // (R12) supply drop forces hold at once
    // Async preset loads only constants; release is clocked
    always_ff @(posedge i_clk or posedge async_src) begin
        if (async_src) begin
            state_r <= MRSS_HOLD;
            cnt_r   <= '0;
        end else if (!i_rst_b) begin
            state_r <= MRSS_HOLD;
            cnt_r   <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Fuses follow the pins while sources hold and freeze after, so a stretch keeps its length
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            fuse_r <= 4'h0;
        end else if (state_r == MRSS_HOLD) begin
            fuse_r <= fuse_s;
        end
    end

    // (R1) (R2) internal and port reset outputs
    always_ff @(posedge i_clk or posedge async_src) begin
        if (async_src) begin
            core_rst_r <= 1'b1;
            io_rst_r   <= 1'b1;
        end else if (!i_rst_b) begin
            core_rst_r <= 1'b1;
            io_rst_r   <= 1'b1;
        end else begin
            core_rst_r <= state_nxt != MRSS_RUN;
            io_rst_r   <= state_nxt != MRSS_RUN;
        end
    end

    // (R1) fetch from reset vector on release
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            fetch_go_r   <= 1'b0;
            fetch_addr_r <= RESET_VECTOR;
        end else begin
            fetch_go_r   <= (state_r == MRSS_STRETCH) && (state_nxt == MRSS_RUN);
            fetch_addr_r <= RESET_VECTOR;
        end
    end

    assign o_rdata      = rdata_r;
    assign o_core_rst   = core_rst_r;
    assign o_io_rst     = io_rst_r;
    assign o_fetch_go   = fetch_go_r;
    assign o_fetch_addr = fetch_addr_r;

    // Checks, clocked, disabled during reset
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    property p_raw_hold;
        raw_rst |=> state_r == MRSS_HOLD && o_core_rst;
    endproperty
    a_raw_hold: assert property (p_raw_hold) // (R13)
        else $error("active source did not hold reset");

    property p_por_hold;
        por_s [*2] |-> o_core_rst && o_io_rst;
    endproperty
    a_por_hold: assert property (p_por_hold) // (R6)
        else $error("power-on level did not hold reset");

    property p_wdt_gate;
        wdt_pulse_r |-> $past(i_wdt_expire) && $past(wdt_en) ##1 !wdt_pulse_r;
    endproperty
    a_wdt_gate: assert property (p_wdt_gate) // (R11)
        else $error("watchdog pulse not one gated cycle");

    property p_wdt_off;
        !wdt_en |=> !wdt_pulse_r;
    endproperty
    a_wdt_off: assert property (p_wdt_off) // (R8)
        else $error("watchdog reset while disabled");

    property p_bod_off;
        state_r == MRSS_RUN && !bod_en && !por_s && !ext_ok && !test_s
            && !wdt_pulse_r && !async_src |=> state_r == MRSS_RUN || async_src;
    endproperty
    a_bod_off: assert property (p_bod_off) // (R9)
        else $error("disabled brown-out caused reset");

    property p_test_hold;
        test_s ##1 test_s |-> o_core_rst;
    endproperty
    a_test_hold: assert property (p_test_hold) // (R10)
        else $error("test-port register did not hold reset");

    property p_ext_min;
        ext_low_s [*3] |-> ext_ok ##1 o_core_rst;
    endproperty
    a_ext_min: assert property (p_ext_min) // (R7)
        else $error("long pin pulse did not reset");

    property p_stretch_len;
        $rose(state_r == MRSS_RUN) |-> $past(cnt_r) == tout_cyc - CNT_W'(1);
    endproperty
    a_stretch_len: assert property (p_stretch_len) // (R3)
        else $error("stretch ended at wrong count");

    property p_fetch;
        o_fetch_go |-> !o_core_rst && $past(o_core_rst) && o_fetch_addr == RESET_VECTOR;
    endproperty
    a_fetch: assert property (p_fetch) // (R1)
        else $error("fetch start not at reset release");

    property p_io_follow;
        o_core_rst |-> o_io_rst;
    endproperty
    a_io_follow: assert property (p_io_follow) // (R2)
        else $error("port reset missing during internal reset");

endmodule : mrss_sequencer

// >>> pkg/mrss_pkg.sv
// Constants and types shared by the reset source sequencer
package mrss_pkg;

    // Register port geometry
    localparam int ADDR_W = 4;                   // Register address width
    localparam int DATA_W = 8;                   // Register data width

    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;  // Enables, read/write
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h1;  // Source levels and state
    localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h2;  // Stretch count, low byte
    localparam logic [ADDR_W-1:0] REG_FUSE   = 4'h3;  // Latched clock select fuses

    // Control register fields and reset value
    localparam int CTRL_WDT_EN_BIT = 0;          // Watchdog reset enable
    localparam int CTRL_BOD_EN_BIT = 1;          // Brown-out reset enable
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;

    // Status register fields
    localparam int STAT_POR_BIT  = 0;            // Supply below power-on level
    localparam int STAT_EXT_BIT  = 1;            // External pin reset seen
    localparam int STAT_WDT_BIT  = 2;            // Watchdog pulse active
    localparam int STAT_BOD_BIT  = 3;            // Brown-out accepted
    localparam int STAT_TEST_BIT = 4;            // Test-port reset register set
    localparam int STAT_HOLD_BIT = 5;            // Sources still active
    localparam int STAT_STR_BIT  = 6;            // Stretch counter running
    localparam int STAT_CORE_BIT = 7;            // Internal reset asserted

    // Synchroniser lanes for pin-side inputs
    localparam int FUSE_W    = 4;                // Clock select fuse width
    localparam int SY_POR    = 0;
    localparam int SY_EXT    = 1;
    localparam int SY_BOD    = 2;
    localparam int SY_TEST   = 3;
    localparam int SY_FUSE   = 4;
    localparam int SYNC_W    = SY_FUSE + FUSE_W;

    // Timing: minimum external pulse, rounded up to whole cycles
    localparam int CLK_PERIOD_NS     = 40;
    localparam int EXT_MIN_PULSE_NS  = 50;
    localparam int EXT_MIN_CYC       = (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [2:0] EXT_MIN_CNT = 3'(EXT_MIN_CYC);

    // Fetch address after release
    localparam int PC_W = 16;
    localparam logic [PC_W-1:0] RESET_VECTOR = 16'h0000;

    // Sequencer states
    typedef enum logic [1:0] {
        MRSS_HOLD,
        MRSS_STRETCH,
        MRSS_RUN
    } mrss_state_t;

endpackage : mrss_pkg

// >>> bench/mrss_src_model.sv
// Behavioural model of the reset pin driver and the supply monitors
`timescale 1ns/10ps
module mrss_src_model
    import mrss_pkg::*;
(
    input  wire logic i_clk,
    output logic      o_por_low,        // Supply below power_on_threshold
    output logic      o_ext_rst_pin_b,  // Reset pin, pulled high when released
    output logic      o_wdt_expire,     // Watchdog period expired
    output logic      o_bod_low,        // Supply below brownout_threshold
    output logic      o_test_rst_reg    // Test-port reset register bit
);
    // Idle: supply good, pin released to its pull-up, no requests
    initial begin
        o_por_low       = 1'b0;
        o_ext_rst_pin_b = 1'b1;
        o_wdt_expire    = 1'b0;
        o_bod_low       = 1'b0;
        o_test_rst_reg  = 1'b0;
    end

    // level sources, changed whenever the caller chooses
    task automatic set_level(input int which, input logic v);
        case (which)
            0: o_por_low <= v;          // Supply rises or falls
            1: o_bod_low <= v;          // Brown-out indication
            default: o_test_rst_reg <= v; // Scan register content
        endcase
    endtask : set_level

    // pin held low for whole cycles, longer than the minimum width
    task automatic pin_low(input int cyc);
        @(posedge i_clk);
        o_ext_rst_pin_b <= 1'b0;
        repeat (cyc) @(posedge i_clk);
        o_ext_rst_pin_b <= 1'b1;
    endtask : pin_low

    // single expiry request in the system clock domain
    task automatic wdt_pulse();
        @(posedge i_clk);
        o_wdt_expire <= 1'b1;
        @(posedge i_clk);
        o_wdt_expire <= 1'b0;
    endtask : wdt_pulse
endmodule : mrss_src_model

// >>> bench/test_mrss_sequencer.sv
// Self-checking testbench for the reset source sequencer
`timescale 1ns/10ps
module test_mrss_sequencer
    import mrss_pkg::*;
;
    localparam int BASE = 2;      // Short stretch base keeps the run brief
    logic              clk;       // 25 MHz clock
    logic              rst_b;     // Bench reset, active low
    logic [FUSE_W-1:0] fuses;     // Clock select fuses
    logic [ADDR_W-1:0] addr;      // Register address
    logic [DATA_W-1:0] wdata;     // Register write data
    logic              wr;        // Write strobe
    logic              rd;        // Read strobe
    logic [DATA_W-1:0] rdata;     // Register read data
    logic              core_rst;  // Internal reset
    logic              io_rst;    // Port pin reset
    logic              fetch_go;  // Release pulse
    logic [PC_W-1:0]   fetch_addr; // First fetch address
    logic              por;       // Model outputs
    logic              pin_b;
    logic              wdt;
    logic              bod;
    logic              test;
    logic [DATA_W-1:0] rv;        // Last read value
    int                n;         // Cycles until release
    int                bad_count = 0;
    int                n_checks = 0;

    mrss_sequencer #(.STRETCH_BASE_CYC(BASE)) i_mrss_sequencer (
        .i_clk(clk), .i_rst_b(rst_b), .i_por_low(por), .i_ext_rst_pin_b(pin_b),
        .i_wdt_expire(wdt), .i_bod_low(bod), .i_test_rst_reg(test),
        .i_clock_select_fuses(fuses), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .o_rdata(rdata), .o_core_rst(core_rst), .o_io_rst(io_rst),
        .o_fetch_go(fetch_go), .o_fetch_addr(fetch_addr));

    mrss_src_model i_mrss_src_model (
        .i_clk(clk), .o_por_low(por), .o_ext_rst_pin_b(pin_b), .o_wdt_expire(wdt),
        .o_bod_low(bod), .o_test_rst_reg(test));

    // Clock generator
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test

    // Compare and count
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // Register write, one strobe cycle
    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : reg_wr

    // Register read, data taken in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp,
                          input string name);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(name, {8'h00, exp}, {8'h00, rdata});
    endtask : reg_rd

    // Wait for release; release shows the reset vector and a single go pulse
    task automatic wait_free(input int tout);
        n = 0;
        while (core_rst !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        // stretch lasts the fuse time-out plus the synchroniser lag
        check("stretch_len", 16'h0001, {15'h0000, (n >= tout && n <= tout + 6)});
        // fetch restarts at the reset vector
        check("fetch_addr", RESET_VECTOR, fetch_addr);
        check("fetch_go", 16'h0001, {15'h0000, fetch_go});
        check("io_rst_free", 16'h0000, {15'h0000, io_rst});
        @(negedge clk);
        check("fetch_go_end", 16'h0000, {15'h0000, fetch_go});
    endtask : wait_free

    // Test register holds reset; stretch follows the fuses; reassertion restarts
    task automatic t_stretch(input logic [FUSE_W-1:0] f);
        @(posedge clk);
        fuses <= f;
        i_mrss_src_model.set_level(2, 1'b1);
        repeat (6) @(negedge clk);
        check("core_rst_test", 16'h0001, {15'h0000, core_rst});
        @(posedge clk);
        i_mrss_src_model.set_level(2, 1'b0);
        repeat ((BASE << f) / 2 + 1) @(posedge clk);
        i_mrss_src_model.set_level(2, 1'b1);
        repeat (4) @(posedge clk);
        i_mrss_src_model.set_level(2, 1'b0);
        wait_free(BASE << f);
        reg_rd(REG_FUSE, {4'h0, f}, "fuse_reg");
    endtask : t_stretch

    // Supply drop resets at once, with no clock edge needed
    task automatic t_por();
        @(posedge clk);
        #10;
        i_mrss_src_model.set_level(0, 1'b1);
        #1;
        check("io_rst_async", 16'h0001, {15'h0000, io_rst});
        check("core_rst_por", 16'h0001, {15'h0000, core_rst});
        repeat (5) @(posedge clk);
        check("core_rst_hold", 16'h0001, {15'h0000, core_rst});
        i_mrss_src_model.set_level(0, 1'b0);
        wait_free(BASE << 1);
    endtask : t_por

    // Watchdog and brown-out obey their enables; pin low resets
    task automatic t_gated();
        reg_wr(REG_CTRL, 8'h00);
        i_mrss_src_model.wdt_pulse();
        @(posedge clk);
        i_mrss_src_model.set_level(1, 1'b1);
        repeat (6) @(negedge clk);
        check("wdt_bod_off", 16'h0000, {15'h0000, core_rst});
        i_mrss_src_model.set_level(1, 1'b0);
        reg_wr(REG_CTRL, 8'h02);
        @(posedge clk);
        #10;
        i_mrss_src_model.set_level(1, 1'b1);
        #1;
        check("bod_on", 16'h0001, {15'h0000, io_rst});
        @(posedge clk);
        i_mrss_src_model.set_level(1, 1'b0);
        wait_free(BASE << 1);
        reg_wr(REG_CTRL, 8'h01);
        i_mrss_src_model.wdt_pulse();
        repeat (3) @(negedge clk);
        check("wdt_on", 16'h0001, {15'h0000, core_rst});
        wait_free(BASE << 1);
        i_mrss_src_model.pin_low(3);
        check("pin_rst", 16'h0001, {15'h0000, core_rst});
        wait_free(BASE << 1);
    endtask : t_gated

    // Control register access, unmapped read, clear by internal reset
    task automatic t_regs();
        reg_rd(REG_CTRL, CTRL_RST, "ctrl_reset");
        reg_wr(REG_CTRL, 8'hff);
        reg_rd(REG_CTRL, 8'h03, "ctrl_rw");
        reg_rd(4'hf, 8'h00, "unmapped");
        reg_rd(REG_STATUS, 8'h00, "status_run");
        reg_wr(REG_CTRL, 8'h01);
        t_stretch(4'h0);
        reg_rd(REG_CTRL, CTRL_RST, "ctrl_cleared");
    endtask : t_regs

    // Hang guard
    initial begin
        #(40 * 30000);
        bad_count++;
        stop_test();
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        fuses = 4'h1;
        addr  = 4'h0;
        wdata = 8'h00;
        wr    = 1'b0;
        rd    = 1'b0;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        wait_free(BASE << 1);
        t_regs();
        t_stretch(4'h1);
        t_stretch(4'h3);
        @(posedge clk);
        fuses <= 4'h1;
        t_por();
        t_gated();
        stop_test();
    end
endmodule : test_mrss_sequencer
